// >>> logic/adcd_defs.vh
// constants for the adc command word decoder: field positions, codes, reset values
// assumes it is included by the shifter and top design files of the decoder, once per file
`ifndef ADCD_DEFS_VH
`define ADCD_DEFS_VH

// command word layout
`define ADCD_WORD_BITS      16
`define ADCD_CNT_W          5
`define ADCD_SEL_TOP        15
`define ADCD_SEL_LO         11
`define ADCD_DATA_HI        10
`define ADCD_SCAN_HI        14
`define ADCD_SCAN_LO        11
`define ADCD_CHSEL_HI       10
`define ADCD_CHSEL_LO       7
`define ADCD_RST_HI         6
`define ADCD_RST_LO         5
`define ADCD_PM_HI          4
`define ADCD_PM_LO          3
`define ADCD_TAG_BIT        2
`define ADCD_SOFTWARE_CONVERT_TRIGGER_BIT      1

// register select codes in bits 15:11
`define ADCD_SEL_CONFIG     5'h10
`define ADCD_SEL_UNIPOLAR   5'h11
`define ADCD_SEL_BIPOLAR    5'h12
`define ADCD_SEL_RANGE      5'h13
`define ADCD_SEL_CSCAN0     5'h14
`define ADCD_SEL_CSCAN1     5'h15
`define ADCD_SEL_SEQUENCE   5'h16
`define ADCD_SEL_RESERVED   5'h1f

// reset field actions
`define ADCD_RST_NONE       2'h0
`define ADCD_RST_FIFO       2'h1
`define ADCD_RST_ALL        2'h2

// scan mode codes
`define ADCD_SCAN_KEEP      4'h0
`define ADCD_SCAN_MANUAL    4'h1
`define ADCD_SCAN_REPEAT    4'h2
`define ADCD_SCAN_STD_INT   4'h3
`define ADCD_SCAN_STD_EXT   4'h4
`define ADCD_SCAN_UPR_INT   4'h5
`define ADCD_SCAN_UPR_EXT   4'h6
`define ADCD_SCAN_CUS_INT   4'h7
`define ADCD_SCAN_CUS_EXT   4'h8

// reset values
`define ADCD_SCAN_RST       4'h1
`define ADCD_CHSEL_RST      4'h0
`define ADCD_PM_RST         2'h0
`define ADCD_DATA_RST       11'h000

// averaging
`define ADCD_ACC_W          19
`define ADCD_AVG_CNT_W      8

`endif

// >>> logic/adcd_sync.v
// two flip-flop synchroniser for the serial pins, one stage pair per bit
// assumes the inputs are asynchronous to mclk
`timescale 1ns/1ns
module adcd_sync
(
    // clock and reset
    input  wire       mclk,
    input  wire       rst_b,
    // pin levels in, synchronised levels out
    input  wire [3:0] pin_in,
    output wire [3:0] pin_sync
);

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1)
        begin : g_bit
            reg meta_r;
            reg sync_r;
            // idle level of each pin is a constant at reset
            always @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    meta_r <= (gi == 0) ? 1'b0 : 1'b1;
                    sync_r <= (gi == 0) ? 1'b0 : 1'b1;
                end
                else
                begin
                    meta_r <= pin_in[gi];
                    sync_r <= meta_r;
                end
            end
            assign pin_sync[gi] = sync_r;
        end
    endgenerate

endmodule // adcd_sync

// >>> logic/adcd_shift.v
// serial command shifter: collects 16 bits per chip-select-low frame
// assumes synchronised sclk, cs_b and din; din taken on sclk rising edge
`timescale 1ns/1ns
`include "adcd_defs.vh"
module adcd_shift
(
    // clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    // synchronised pins
    input  wire        sclk_s,
    input  wire        cs_b_s,
    input  wire        din_s,
    // frame results
    output reg  [15:0] word_r,
    output reg         word_valid_r,
    output reg         cs_rise_r
);

    reg        sclk_d_r;
    reg        cs_b_d_r;
    reg [15:0] shift_r;
    reg [4:0]  count_r;

    wire sclk_rise = sclk_s & ~sclk_d_r;
    wire cs_fall   = cs_b_d_r & ~cs_b_s;

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sclk_d_r     <= 1'b0;
            cs_b_d_r     <= 1'b1;
            shift_r      <= 16'h0000;
            count_r      <= 5'h00;
            word_r       <= 16'h0000;
            word_valid_r <= 1'b0;
            cs_rise_r    <= 1'b0;
        end
        else
        begin
            sclk_d_r     <= sclk_s;
            cs_b_d_r     <= cs_b_s;
            word_valid_r <= 1'b0;
            cs_rise_r    <= cs_b_s & ~cs_b_d_r;
            if (cs_fall)
            begin
                count_r <= 5'h00;
            end
            else if (!cs_b_s && sclk_rise && count_r != `ADCD_WORD_BITS)
            begin
                // msb first, word decoded only once all 16 bits are in
                shift_r <= {shift_r[14:0], din_s};
                count_r <= count_r + 5'h01;
                if (count_r == 5'h0f)
                begin
                    word_r       <= {shift_r[14:0], din_s};
                    word_valid_r <= 1'b1;
                end
            end
        end
    end

endmodule // adcd_shift

// >>> logic/adcd_top.v
// adc command word decoder: serial command decode, mode control, averaging
// assumes a conversion core and fifo on mclk; serial pins arrive asynchronously
//
// What this block does
// - averaging mode emits only the average of the programmed conversion count
// - averaging works only with internal clock modes, never serial-clock conversions
// - standard and upper scans convert differential pairs a second time for the partner channel
// - all register writes arrive as serial command words on the data input
// - bit 15 low means a mode control write, bits 14:1 are its fields, bit 0 unused
// - bit 15 high: bits 15:11 pick the target register, bits 10:0 data
// - mode bits 10:7 select input channel n, default 0000
// - reset field: 01 clears fifo, 10 restores all defaults and fifo
// - mode bits 4:3 select power management, default 00
// - channel id bit in external mode frames output as 4-bit channel plus result
// - internal clock mode results always carry the channel address
// - software convert in internal mode starts conversion on chip-select rise
// - software convert bit clears itself once the conversion completes
// - scan code 0000 keeps mode and channel, still updates bits 6:3 and 1
`timescale 1ns/1ns
`include "adcd_defs.vh"
module adcd_top
(
    // clock and reset
    input  wire        mclk,
    input  wire        rst_b,
    // serial pins
    input  wire        sclk,
    input  wire        cs_b,
    input  wire        din,
    input  wire        convert_start_pin_b,
    // conversion core
    input  wire        conv_done,
    input  wire        result_valid,
    input  wire [11:0] result_data,
    input  wire [3:0]  result_chan,
    input  wire        avg_request,
    input  wire [2:0]  avg_log2,
    input  wire [7:0]  pair_diff_mask,
    // mode control state
    output reg  [3:0]  scan_mode_r,
    output reg  [3:0]  input_channel_number_r,
    output reg  [1:0]  power_management_select_r,
    output reg         tag_output_with_channel_r,
    output reg         software_convert_trigger_r,
    output wire        internal_clock_mode,
    output wire        averaging_active,
    // other registers
    output reg  [10:0] config_r,
    output reg  [10:0] unipolar_r,
    output reg  [10:0] bipolar_r,
    output reg  [10:0] range_r,
    output reg  [10:0] cscan0_r,
    output reg  [10:0] cscan1_r,
    output reg  [10:0] sequence_r,
    // actions
    output reg         conv_start_r,
    output reg         fifo_clear_r,
    output reg         soft_reset_r,
    output reg         pair_rescan_r,
    output reg  [3:0]  pair_rescan_chan_r,
    // result fifo write side
    output reg         fifo_wr_r,
    output reg  [15:0] fifo_wdata_r
);

    wire [3:0]  pin_sync;
    wire [15:0] cmd_word;
    wire        cmd_valid;
    wire        cs_rise;
    reg         cnv_d_r;

    adcd_sync u_sync
    (
        .mclk        (mclk),
        .rst_b       (rst_b),
        .pin_in      ({convert_start_pin_b, din, cs_b, sclk}),
        .pin_sync    (pin_sync)
    );

    adcd_shift u_shift
    (
        .mclk         (mclk),
        .rst_b        (rst_b),
        .sclk_s       (pin_sync[0]),
        .cs_b_s       (pin_sync[1]),
        .din_s        (pin_sync[2]),
        .word_r       (cmd_word),
        .word_valid_r (cmd_valid),
        .cs_rise_r    (cs_rise)
    );

    // command fields
    wire [4:0]  sel_code  = cmd_word[`ADCD_SEL_TOP:`ADCD_SEL_LO];
    wire [10:0] reg_data  = cmd_word[`ADCD_DATA_HI:0];
    wire [3:0]  new_scan  = cmd_word[`ADCD_SCAN_HI:`ADCD_SCAN_LO];
    wire [1:0]  new_rst   = cmd_word[`ADCD_RST_HI:`ADCD_RST_LO];
    wire        mode_wr   = cmd_valid & ~cmd_word[`ADCD_SEL_TOP];
    wire        full_rst  = mode_wr & (new_rst == `ADCD_RST_ALL);

    // clock mode follows the scan mode
    assign internal_clock_mode = (scan_mode_r == `ADCD_SCAN_REPEAT)  ||
                                 (scan_mode_r == `ADCD_SCAN_STD_INT) ||
                                 (scan_mode_r == `ADCD_SCAN_UPR_INT) ||
                                 (scan_mode_r == `ADCD_SCAN_CUS_INT);
    // averaging gated by internal clocking
    assign averaging_active = avg_request & internal_clock_mode;

    wire auto_scan = (scan_mode_r == `ADCD_SCAN_STD_INT) ||
                     (scan_mode_r == `ADCD_SCAN_STD_EXT) ||
                     (scan_mode_r == `ADCD_SCAN_UPR_INT) ||
                     (scan_mode_r == `ADCD_SCAN_UPR_EXT);

    reg [3:0]  scan_nxt;
    reg [3:0]  chsel_nxt;
    reg [1:0]  pm_nxt;
    reg        tag_nxt;
    reg        software_convert_trigger_nxt;
    reg [10:0] config_nxt;
    reg [10:0] unipolar_nxt;
    reg [10:0] bipolar_nxt;
    reg [10:0] range_nxt;
    reg [10:0] cscan0_nxt;
    reg [10:0] cscan1_nxt;
    reg [10:0] sequence_nxt;

    always @*
    begin
        scan_nxt     = scan_mode_r;
        chsel_nxt    = input_channel_number_r;
        pm_nxt       = power_management_select_r;
        tag_nxt      = tag_output_with_channel_r;
        software_convert_trigger_nxt    = software_convert_trigger_r;
        config_nxt   = config_r;
        unipolar_nxt = unipolar_r;
        bipolar_nxt  = bipolar_r;
        range_nxt    = range_r;
        cscan0_nxt   = cscan0_r;
        cscan1_nxt   = cscan1_r;
        sequence_nxt = sequence_r;
        // self clear after triggered conversion; a new write below wins
        if (conv_done)
        begin
            software_convert_trigger_nxt = 1'b0;
        end
        if (full_rst)
        begin
            // every register back to default
            scan_nxt     = `ADCD_SCAN_RST;
            chsel_nxt    = `ADCD_CHSEL_RST;
            pm_nxt       = `ADCD_PM_RST;
            tag_nxt      = 1'b0;
            software_convert_trigger_nxt    = 1'b0;
            config_nxt   = `ADCD_DATA_RST;
            unipolar_nxt = `ADCD_DATA_RST;
            bipolar_nxt  = `ADCD_DATA_RST;
            range_nxt    = `ADCD_DATA_RST;
            cscan0_nxt   = `ADCD_DATA_RST;
            cscan1_nxt   = `ADCD_DATA_RST;
            sequence_nxt = `ADCD_DATA_RST;
        end
        else if (mode_wr)
        begin
            // bit 15 low: mode control write
            pm_nxt    = cmd_word[`ADCD_PM_HI:`ADCD_PM_LO];
            software_convert_trigger_nxt = cmd_word[`ADCD_SOFTWARE_CONVERT_TRIGGER_BIT];
            if (new_scan != `ADCD_SCAN_KEEP)
            begin
                // scan code 0000 keeps mode, channel and tag
                scan_nxt  = new_scan;
                chsel_nxt = cmd_word[`ADCD_CHSEL_HI:`ADCD_CHSEL_LO];
                tag_nxt   = cmd_word[`ADCD_TAG_BIT];
            end
        end
        else if (cmd_valid)
        begin
            // bit 15 high: route data by select code, others ignored
            case (sel_code)
                `ADCD_SEL_CONFIG:   config_nxt   = reg_data;
                `ADCD_SEL_UNIPOLAR: unipolar_nxt = reg_data;
                `ADCD_SEL_BIPOLAR:  bipolar_nxt  = reg_data;
                `ADCD_SEL_RANGE:    range_nxt    = reg_data;
                `ADCD_SEL_CSCAN0:   cscan0_nxt   = reg_data;
                `ADCD_SEL_CSCAN1:   cscan1_nxt   = reg_data;
                `ADCD_SEL_SEQUENCE: sequence_nxt = reg_data;
                default:            config_nxt   = config_r;
            endcase
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scan_mode_r                <= `ADCD_SCAN_RST;
            input_channel_number_r     <= `ADCD_CHSEL_RST;
            power_management_select_r  <= `ADCD_PM_RST;
            tag_output_with_channel_r  <= 1'b0;
            software_convert_trigger_r <= 1'b0;
            config_r                   <= `ADCD_DATA_RST;
            unipolar_r                 <= `ADCD_DATA_RST;
            bipolar_r                  <= `ADCD_DATA_RST;
            range_r                    <= `ADCD_DATA_RST;
            cscan0_r                   <= `ADCD_DATA_RST;
            cscan1_r                   <= `ADCD_DATA_RST;
            sequence_r                 <= `ADCD_DATA_RST;
            fifo_clear_r               <= 1'b0;
            soft_reset_r               <= 1'b0;
        end
        else
        begin
            scan_mode_r                <= scan_nxt;
            input_channel_number_r     <= chsel_nxt;
            power_management_select_r  <= pm_nxt;
            tag_output_with_channel_r  <= tag_nxt;
            software_convert_trigger_r <= software_convert_trigger_nxt;
            config_r                   <= config_nxt;
            unipolar_r                 <= unipolar_nxt;
            bipolar_r                  <= bipolar_nxt;
            range_r                    <= range_nxt;
            cscan0_r                   <= cscan0_nxt;
            cscan1_r                   <= cscan1_nxt;
            sequence_r                 <= sequence_nxt;
            // fifo clear on 01 and with a full reset
            fifo_clear_r               <= mode_wr & ((new_rst == `ADCD_RST_FIFO) | full_rst);
            soft_reset_r               <= full_rst;
        end
    end

    // conversion start, internal clock mode only: pin pulse, or chip-select rise under software convert
    wire cnv_rise = pin_sync[3] & ~cnv_d_r;

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnv_d_r      <= 1'b1;
            conv_start_r <= 1'b0;
        end
        else
        begin
            cnv_d_r      <= pin_sync[3];
            if (internal_clock_mode && software_convert_trigger_r)
            begin
                conv_start_r <= cs_rise;
            end
            else
            begin
                conv_start_r <= cnv_rise & internal_clock_mode;
            end
        end
    end

    // averaging accumulator and output framing
    reg  [`ADCD_ACC_W-1:0]     acc_r;
    reg  [`ADCD_AVG_CNT_W-1:0] avg_cnt_r;
    wire [`ADCD_ACC_W-1:0]     acc_sum  = acc_r + {7'h00, result_data};
    wire [`ADCD_ACC_W-1:0]     acc_avg  = acc_sum >> avg_log2;
    wire [`ADCD_AVG_CNT_W-1:0] cnt_inc  = avg_cnt_r + 8'h01;
    wire [`ADCD_AVG_CNT_W-1:0] cnt_goal = 8'h01 << avg_log2;
    wire                       tag_on   = tag_output_with_channel_r | internal_clock_mode;
    reg                        emit;
    reg  [11:0]                emit_val;

    always @*
    begin
        emit     = 1'b0;
        emit_val = result_data;
        if (result_valid)
        begin
            if (!averaging_active)
            begin
                emit = 1'b1;
            end
            else if (cnt_inc == cnt_goal)
            begin
                // only the average goes to the fifo
                emit     = 1'b1;
                emit_val = acc_avg[11:0];
            end
        end
    end

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            acc_r              <= 19'h0_0000;
            avg_cnt_r          <= 8'h00;
            fifo_wr_r          <= 1'b0;
            fifo_wdata_r       <= 16'h0000;
            pair_rescan_r      <= 1'b0;
            pair_rescan_chan_r <= 4'h0;
        end
        else
        begin
            fifo_wr_r     <= emit;
            pair_rescan_r <= 1'b0;
            if (!averaging_active || fifo_clear_r)
            begin
                acc_r     <= 19'h0_0000;
                avg_cnt_r <= 8'h00;
            end
            else if (result_valid)
            begin
                acc_r     <= emit ? 19'h0_0000 : acc_sum;
                avg_cnt_r <= emit ? 8'h00 : cnt_inc;
            end
            if (emit)
            begin
                // channel tag forced in internal mode
                fifo_wdata_r <= tag_on ? {result_chan, emit_val} : {4'h0, emit_val};
                if (auto_scan && pair_diff_mask[result_chan[3:1]] && !result_chan[0])
                begin
                    // standard and upper scans convert a pair again for its odd channel
                    pair_rescan_r      <= 1'b1;
                    pair_rescan_chan_r <= {result_chan[3:1], 1'b1};
                end
            end
        end
    end

endmodule // adcd_top

// >>> test/adcd_host_model.sv
// host model: writes command words over the three-wire serial port
// assumes the bench calls send just after a rising mclk edge
`timescale 1ns/1ns
module adcd_host_model
(
    // clock
    input  wire logic mclk,
    // serial pins
    output logic      sclk,
    output logic      cs_b,
    output logic      din
);
    localparam int HALF = 4;

    initial
    begin
        sclk = 1'b0;
        cs_b = 1'b1;
        din  = 1'b0;
    end

    // n bits msb first in one low frame; reserved code 11111 is never sent
    task automatic send(input logic [15:0] w, input int n);
        int i;
        cs_b <= 1'b0;
        repeat (HALF) @(posedge mclk);
        for (i = 15; i > 15 - n; i--)
        begin
            din  <= w[i];
            sclk <= 1'b0;
            repeat (HALF) @(posedge mclk);
            sclk <= 1'b1;
            repeat (HALF) @(posedge mclk);
        end
        sclk <= 1'b0;
        repeat (HALF) @(posedge mclk);
        cs_b <= 1'b1;
        din  <= ~din;
        repeat (HALF) @(posedge mclk);
    endtask
endmodule // adcd_host_model

// >>> test/adcd_chk_assertions.sv
// checker for the command word decoder, sees only the top ports
// assumes one mclk domain with rst_b active low
`timescale 1ns/1ns
module adcd_chk
(
    input logic        mclk,
    input logic        rst_b,
    input logic        result_valid,
    input logic [11:0] result_data,
    input logic [3:0]  scan_mode_r,
    input logic [3:0]  input_channel_number_r,
    input logic [1:0]  power_management_select_r,
    input logic        tag_output_with_channel_r,
    input logic        software_convert_trigger_r,
    input logic        internal_clock_mode,
    input logic        averaging_active,
    input logic [10:0] config_r,
    input logic        conv_start_r,
    input logic        fifo_clear_r,
    input logic        soft_reset_r,
    input logic        pair_rescan_r,
    input logic [3:0]  pair_rescan_chan_r,
    input logic        fifo_wr_r,
    input logic [15:0] fifo_wdata_r
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    a_avg_internal: assert property (
        averaging_active |-> internal_clock_mode)
        else $error("averaging outside internal clock mode");
    a_mode_clock_map: assert property (
        internal_clock_mode == (scan_mode_r inside {4'h2, 4'h3, 4'h5, 4'h7}))
        else $error("clock mode does not follow scan code");
    a_start_internal: assert property (
        conv_start_r |-> $past(internal_clock_mode))
        else $error("conversion start outside internal clock mode");
    a_full_reset_regs: assert property (
        soft_reset_r |-> scan_mode_r == 4'h1 && input_channel_number_r == 4'h0
            && power_management_select_r == 2'h0 && !tag_output_with_channel_r
            && !software_convert_trigger_r && config_r == 11'h000)
        else $error("full reset left a register off default");
    a_full_reset_fifo: assert property (
        soft_reset_r |-> fifo_clear_r)
        else $error("full reset without fifo clear");
    a_clear_one_cycle: assert property (
        fifo_clear_r |=> !fifo_clear_r)
        else $error("fifo clear longer than one cycle");
    a_ext_untagged: assert property (
        fifo_wr_r && !$past(tag_output_with_channel_r) && !$past(internal_clock_mode)
            |-> fifo_wdata_r[15:12] == 4'h0)
        else $error("untagged result carries a channel");
    a_direct_result: assert property (
        result_valid && !averaging_active
            |=> fifo_wr_r && fifo_wdata_r[11:0] == $past(result_data))
        else $error("plain result not written next cycle");
    a_rescan_pair: assert property (
        pair_rescan_r |-> fifo_wr_r && pair_rescan_chan_r[0]
            && $past(scan_mode_r) inside {4'h3, 4'h4, 4'h5, 4'h6})
        else $error("pair rescan malformed");
endmodule // adcd_chk

bind adcd_top adcd_chk u_chk
(
    .mclk(mclk), .rst_b(rst_b), .result_valid(result_valid), .result_data(result_data),
    .scan_mode_r(scan_mode_r), .input_channel_number_r(input_channel_number_r),
    .power_management_select_r(power_management_select_r),
    .tag_output_with_channel_r(tag_output_with_channel_r),
    .software_convert_trigger_r(software_convert_trigger_r),
    .internal_clock_mode(internal_clock_mode), .averaging_active(averaging_active),
    .config_r(config_r), .conv_start_r(conv_start_r), .fifo_clear_r(fifo_clear_r),
    .soft_reset_r(soft_reset_r), .pair_rescan_r(pair_rescan_r),
    .pair_rescan_chan_r(pair_rescan_chan_r), .fifo_wr_r(fifo_wr_r),
    .fifo_wdata_r(fifo_wdata_r)
);

// >>> test/tb_top.sv
// testbench for the command word decoder: serial writes, starts, result path
// assumes the host model drives the serial pins and the bench plays the core
`timescale 1ns/1ns
module tb_top;
    logic        mclk, rst_b, cps_b, conv_done, result_valid, avg_request;
    logic [11:0] result_data;
    logic [3:0]  result_chan;
    logic [2:0]  avg_log2;
    logic [7:0]  pair_diff_mask;
    wire         sclk, cs_b, din, tag, swc, intl, avg_act, cstart, fclr, srst, prs, fwr;
    wire  [3:0]  scan, chn, prc;
    wire  [1:0]  pm;
    wire  [15:0] fwd;
    wire  [10:0] rg0, rg1, rg2, rg3, rg4, rg5, rg6;
    int          mismatches = 0;
    int          checked = 0;
    int          n_start = 0;
    int          n_wr = 0;
    int          n_clr = 0;
    int          n_srst = 0;
    int          k, n0;
    logic [15:0] last_wd;
    logic [3:0]  last_rc;

    adcd_host_model u_host (.mclk(mclk), .sclk(sclk), .cs_b(cs_b), .din(din));

    adcd_top dut
    (
        .mclk(mclk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .din(din),
        .convert_start_pin_b(cps_b), .conv_done(conv_done), .result_valid(result_valid),
        .result_data(result_data), .result_chan(result_chan), .avg_request(avg_request),
        .avg_log2(avg_log2), .pair_diff_mask(pair_diff_mask), .scan_mode_r(scan),
        .input_channel_number_r(chn), .power_management_select_r(pm),
        .tag_output_with_channel_r(tag), .software_convert_trigger_r(swc),
        .internal_clock_mode(intl), .averaging_active(avg_act), .config_r(rg0),
        .unipolar_r(rg1), .bipolar_r(rg2), .range_r(rg3), .cscan0_r(rg4), .cscan1_r(rg5),
        .sequence_r(rg6), .conv_start_r(cstart), .fifo_clear_r(fclr), .soft_reset_r(srst),
        .pair_rescan_r(prs), .pair_rescan_chan_r(prc), .fifo_wr_r(fwr), .fifo_wdata_r(fwd)
    );

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // event counters on the design's pulses
    always @(posedge mclk)
    begin
        n_start <= n_start + int'(cstart === 1'b1);
        n_clr   <= n_clr + int'(fclr === 1'b1);
        n_srst  <= n_srst + int'(srst === 1'b1);
        n_wr    <= n_wr + int'(fwr === 1'b1);
        if (fwr === 1'b1) last_wd <= fwd;
        if (prs === 1'b1) last_rc <= prc;
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [15:0] mw(logic [3:0] s, logic [3:0] c, logic [1:0] r,
                                       logic [1:0] p, logic t, logic v);
        return {1'b0, s, c, r, p, t, v, 1'b1};
    endfunction

    function automatic logic [10:0] reg_at(int i);
        case (i)
            0: return rg0;
            1: return rg1;
            2: return rg2;
            3: return rg3;
            4: return rg4;
            5: return rg5;
            default: return rg6;
        endcase
    endfunction

    task automatic wr(input logic [15:0] w);
        @(posedge mclk);
        u_host.send(w, 16);
        repeat (8) @(posedge mclk);
    endtask

    task automatic pin_pulse;
        @(posedge mclk);
        cps_b <= 1'b0;
        repeat (4) @(posedge mclk);
        cps_b <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask

    task automatic res(input logic [3:0] c, input logic [11:0] d);
        @(posedge mclk);
        result_valid <= 1'b1;
        result_chan  <= c;
        result_data  <= d;
        @(posedge mclk);
        result_valid <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    task automatic close_out;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        close_out();
    end

    initial
    begin
        rst_b = 1'b0;
        cps_b = 1'b1;
        conv_done = 1'b0;
        result_valid = 1'b0;
        avg_request = 1'b0;
        result_data = 12'h000;
        result_chan = 4'h0;
        avg_log2 = 3'h0;
        pair_diff_mask = 8'h04;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (4) @(posedge mclk);
        chk(16'(scan), 16'h0001, "scan reset");
        chk(16'({chn, pm, tag, swc}), 16'h0000, "mode fields reset");
        $display("test reset values done");
        for (k = 0; k < 7; k++)
            wr(16'h85a0 + 16'(k * 16'h0801));
        wr(16'hbfff);
        u_host.send(16'h8000, 12);
        for (k = 0; k < 7; k++)
            chk(16'(reg_at(k)), 16'(11'h5a0 + k), "register select");
        $display("test register select done");
        wr(mw(4'h3, 4'h9, 2'h0, 2'h2, 1'b1, 1'b0));
        chk({scan, chn, pm, 3'h0, tag, 1'b0, intl}, 16'h3985, "mode write");
        wr(mw(4'h0, 4'h5, 2'h0, 2'h1, 1'b0, 1'b1));
        chk({scan, chn, pm, 3'h0, tag, 1'b0, swc}, 16'h3945, "scan keep");
        chk(16'(n_start), 16'h0001, "start on chip select rise");
        pin_pulse();
        chk(16'(n_start), 16'h0001, "pin refused under soft trigger");
        @(posedge mclk);
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
        repeat (2) @(posedge mclk);
        chk(16'(swc), 16'h0000, "soft trigger self clear");
        pin_pulse();
        chk(16'(n_start), 16'h0002, "pin start");
        wr(mw(4'h0, 4'h0, 2'h0, 2'h1, 1'b0, 1'b1));
        chk(16'(n_start), 16'h0003, "rearmed soft trigger");
        $display("test conversion start done");
        res(4'h4, 12'habc);
        chk(last_wd, 16'h4abc, "internal result tagged");
        chk(16'(last_rc), 16'h0005, "pair rescan channel");
        avg_log2 <= 3'h2;
        avg_request <= 1'b1;
        @(posedge mclk);
        n0 = n_wr;
        chk(16'(avg_act), 16'h0001, "averaging on internal");
        for (k = 0; k < 4; k++)
            res(4'h3, 12'(100 + 2 * k));
        chk(16'(n_wr - n0), 16'h0001, "one averaged write");
        chk(last_wd, 16'h3067, "averaged value");
        avg_request <= 1'b0;
        $display("test result path done");
        wr(mw(4'h0, 4'h0, 2'h1, 2'h0, 1'b0, 1'b0));
        chk(16'({n_clr[3:0], n_srst[3:0], scan}), 16'h0103, "fifo clear only");
        wr(mw(4'h0, 4'h0, 2'h2, 2'h0, 1'b0, 1'b0));
        chk(16'({n_clr[3:0], n_srst[3:0], scan}), 16'h0211, "full reset");
        chk(16'(rg0), 16'h0000, "full reset config");
        wr(mw(4'h4, 4'h2, 2'h0, 2'h0, 1'b0, 1'b0));
        avg_request <= 1'b1;
        pin_pulse();
        chk(16'({avg_act, 3'h0, n_start[3:0]}), 16'h0003, "external mode");
        res(4'h2, 12'h123);
        chk(last_wd, 16'h0123, "external untagged");
        wr(mw(4'h6, 4'h2, 2'h0, 2'h0, 1'b1, 1'b0));
        res(4'h6, 12'h456);
        chk(last_wd, 16'h6456, "external tagged");
        $display("test reset and external done");
        close_out();
    end
endmodule // tb_top
